// *** inc/sai_rx_defs.svh ***
`ifndef SAI_RX_DEFS_SVH
`define SAI_RX_DEFS_SVH


// Register indices on the register port
`define IDX_CTRL 2'h0
`define IDX_DATA_A 2'h1
`define IDX_DATA_B 2'h2

// Writable control bits: enables, length, left/right, bits 8 to 12
`define CTRL_WRITE_MASK 16'h1FB3
`define CTRL_WIDTH 16

// Word length codes
`define WLEN_16 2'h0
`define WLEN_24 2'h1
`define WLEN_32 2'h2

// Interrupt vector program addresses
`define VEC_LEFT_LOW 8'h16
`define VEC_RIGHT_LOW 8'h18
`define VEC_EXC_LOW 8'h1A
`define VEC_LEFT_HIGH 8'h46
`define VEC_RIGHT_HIGH 8'h48
`define VEC_EXC_HIGH 8'h4A

`define NUM_RECEIVERS 2
`define SHIFT_WIDTH 32
`define DATA_WIDTH 24

`endif

// *** inc/sai_rx_pkg.sv ***
package sai_rx_pkg;

	// Control/status word as software sees it
	typedef struct packed {
		logic rx_right_full_flag;
		logic rx_left_full_flag;
		logic reserved13;
		logic rx_vector_bank_sel;
		logic rx_irq_enable;
		logic rx_truncate_sel;
		logic rx_ws_early_sel;
		logic rx_clock_polarity_sel;
		logic rx_left_right_polarity;
		logic reserved6;
		logic [1:0] rx_word_length_field;
		logic reserved3;
		logic reserved2;
		logic receiver_b_enable;
		logic receiver_a_enable;
	} ctrl_type;

	// Link pins travelling through the synchroniser together
	typedef struct packed {
		logic sck;
		logic ws;
		logic [1:0] sd;
	} pins_type;

	// Receiver sequencing
	typedef enum logic [1:0] {
		RX_IDLE,
		RX_ALIGN,
		RX_RUN
	} rx_state_type;

endpackage

// *** tb/audio_source_model.sv ***
module audio_source_model (
	// Bench clock, only to keep line changes away from its rising edge
	input wire logic clk,
	// Link pins
	output logic sckPin,
	output logic wsPin,
	output logic [1:0] sdPin,
	// Frame format
	input wire logic clockPolarity,
	input wire logic wsEarly
);
	timeunit 1ns;
	timeprecision 1ns;
	logic sck = 1'b1;

	// Lines start at a defined level
	initial begin
		wsPin = 1'b0;
		sdPin = 2'b00;
	end

	// Clock parks between frames; positive polarity is the same wave inverted
	assign sckPin = sck ^ clockPolarity;

	// One word, MSB first; lines move half a period before the sampling edge
	task automatic word(input logic ws, input logic [31:0] a, input logic [31:0] b, input int n);
		// Start on a falling edge; 160 ns steps then stay on falling edges
		@(negedge clk);
		for (int i = n - 1; i >= 0; i--) begin
			sck = 1'b0;
			wsPin = (wsEarly && i == 0) ? ~ws : ws;
			sdPin = {b[i], a[i]};
			#160;
			sck = 1'b1;
			#160;
		end
		// Released data must not look like a held bit
		sdPin = ~sdPin;
	endtask
endmodule

// *** tb/serial_audio_receiver_ctrl_bench.sv ***
module serial_audio_receiver_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, reset, clkEnable, softReset, stopMode, regWrite, regRead;
	logic [1:0] regAddr;
	logic [23:0] regWriteData, regReadData;
	logic sckPin, wsPin, irqRequest, clockPolarity, wsEarly;
	logic [1:0] sdPin;
	logic [7:0] irqVector;
	int error_cnt = 0;
	int n_checks = 0;
	int cycles = 0;

	serial_audio_receiver_ctrl u_dut (.clk(clk), .reset(reset), .clkEnable(clkEnable),
		.softReset(softReset), .stopMode(stopMode), .regAddr(regAddr),
		.regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
		.regReadData(regReadData), .serialClockPin(sckPin), .rx_word_select_pin(wsPin),
		.rx_serial_data_in(sdPin), .irqRequest(irqRequest), .irqVector(irqVector));
	audio_source_model u_src (.clk(clk), .sckPin(sckPin), .wsPin(wsPin), .sdPin(sdPin),
		.clockPolarity(clockPolarity), .wsEarly(wsEarly));

	// System clock, 25 MHz
	always #20 clk = ~clk;

	task automatic check(input logic [23:0] seen, input logic [23:0] want);
		n_checks++;
		if (seen !== want) begin
			error_cnt++;
			$display("Error at %0t ns: saw %h, wanted %h", $time, seen, want);
		end
	endtask

	function automatic logic [23:0] irqw();
		return {15'h0000, irqRequest, irqVector};
	endfunction

	// Link events are asynchronous, so give them a few clocks to land
	task automatic settle;
		repeat (4) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regWriteData <= {8'h00, d};
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rchk(input logic [1:0] a, input logic [23:0] want);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		check(regReadData, want);
	endtask

	task automatic test_regs;
		rchk(2'h0, 24'h000000);
		// A write while the clock enable is low must leave no trace
		@(posedge clk);
		clkEnable <= 1'b0;
		wr(2'h0, 16'hFFFF);
		clkEnable <= 1'b1;
		rchk(2'h0, 24'h000000);
		wr(2'h0, 16'hFFFF);
		rchk(2'h0, 24'h001FB3);
		wr(2'h3, 16'hFFFF);
		rchk(2'h3, 24'h000000);
		@(posedge clk);
		softReset <= 1'b1;
		@(posedge clk);
		softReset <= 1'b0;
		rchk(2'h0, 24'h000000);
		$display("test_regs done");
	endtask

	task automatic test_pcm16;
		wr(2'h0, 16'h0C03);
		u_src.word(1'b1, 32'h1111, 32'h2222, 16);
		u_src.word(1'b0, 32'hA5C3, 32'h3C5A, 16);
		u_src.word(1'b1, 32'h5A3C, 32'hC3A5, 16);
		settle;
		check(irqw(), 24'h000116);
		rchk(2'h0, 24'h004C03);
		rchk(2'h1, 24'hA5C300);
		check(irqw(), 24'h000116);
		rchk(2'h2, 24'h3C5A00);
		settle;
		check({23'h000000, irqRequest}, 24'h000000);
		u_src.word(1'b0, 32'h1234, 32'h4321, 16);
		settle;
		check(irqw(), 24'h000118);
		rchk(2'h1, 24'h5A3C00);
		u_src.word(1'b1, 32'h0000, 32'h0000, 16);
		settle;
		check(irqw(), 24'h00011A);
		rchk(2'h1, 24'h123400);
		rchk(2'h2, 24'h432100);
		rchk(2'h0, 24'h00CC03);
		rchk(2'h1, 24'h123400);
		rchk(2'h2, 24'h432100);
		rchk(2'h0, 24'h000C03);
		wr(2'h0, 16'h0000);
		$display("test_pcm16 done");
	endtask

	// Polarity is swapped only while the receiver is off
	task automatic test_i2s32;
		clockPolarity <= 1'b1;
		wsEarly <= 1'b1;
		wr(2'h0, 16'h1FA1);
		u_src.word(1'b0, 32'h00000000, 32'h00000000, 32);
		u_src.word(1'b1, 32'h12345678, 32'h00000000, 32);
		settle;
		check(irqw(), 24'h000146);
		rchk(2'h1, 24'h345678);
		u_src.word(1'b0, 32'h9ABCDEF0, 32'h00000000, 32);
		settle;
		check(irqw(), 24'h000148);
		wr(2'h0, 16'h17A1);
		settle;
		check({23'h000000, irqRequest}, 24'h000000);
		rchk(2'h0, 24'h0097A1);
		@(posedge clk);
		stopMode <= 1'b1;
		rchk(2'h0, 24'h0017A1);
		@(posedge clk);
		stopMode <= 1'b0;
		wr(2'h0, 16'h0000);
		$display("test_i2s32 done");
	endtask

	// 24-bit words and 32-bit first-24 truncation, receiver B alone
	task automatic test_formats;
		clockPolarity <= 1'b0;
		wsEarly <= 1'b0;
		wr(2'h0, 16'h0012);
		u_src.word(1'b0, 32'h00000000, 32'h00ABCDEF, 24);
		u_src.word(1'b1, 32'h00000000, 32'h00000000, 24);
		settle;
		rchk(2'h0, 24'h004012);
		rchk(2'h2, 24'hABCDEF);
		rchk(2'h1, 24'h000000);
		rchk(2'h0, 24'h000012);
		wr(2'h0, 16'h0000);
		wr(2'h0, 16'h0022);
		u_src.word(1'b0, 32'h00000000, 32'h00000000, 32);
		u_src.word(1'b1, 32'h00000000, 32'h13579BDF, 32);
		u_src.word(1'b0, 32'h00000000, 32'h00000000, 32);
		settle;
		rchk(2'h2, 24'h13579B);
		wr(2'h0, 16'h0000);
		$display("test_formats done");
	endtask

	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Hang guard, well above the expected run of about 2700 cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			complete_run;
		end
	end

	initial begin
		clk = 1'b0;
		reset = 1'b1;
		clkEnable = 1'b1;
		softReset = 1'b0;
		stopMode = 1'b0;
		regAddr = 2'h0;
		regWriteData = 24'h000000;
		regWrite = 1'b0;
		regRead = 1'b0;
		clockPolarity = 1'b0;
		wsEarly = 1'b0;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		test_regs;
		test_pcm16;
		test_i2s32;
		test_formats;
		complete_run;
	end
endmodule

// *** tb/serial_audio_receiver_ctrl_sva.sv ***
module serial_audio_receiver_ctrl_sva (
	// Clock and resets
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEnable,
	input wire logic softReset,
	input wire logic stopMode,
	// Register port
	input wire logic [1:0] regAddr,
	input wire logic [23:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [23:0] regReadData,
	// Interrupt
	input wire logic irqRequest,
	input wire logic [7:0] irqVector
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] ctrlShadow;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// Own copy of the writable control bits, so readback is judged independently
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrlShadow <= 16'h0000;
		end else if (clkEnable && softReset) begin
			ctrlShadow <= 16'h0000;
		end else if (clkEnable && regWrite && regAddr == 2'h0) begin
			ctrlShadow <= regWriteData[15:0] & 16'h1FB3;
		end
	end

	sequence sCtrlRead;
		clkEnable && regRead && regAddr == 2'h0;
	endsequence
	sequence sIrqOffWrite;
		clkEnable && regWrite && regAddr == 2'h0 && !regWriteData[11];
	endsequence
	sequence sStopRead;
		stopMode ##1 (stopMode && regRead && regAddr == 2'h0);
	endsequence

	AST_READ_IDLE: assert property (clkEnable && !regRead |=> regReadData == 24'h000000)
		else $error("read data not idle");
	AST_UNMAPPED: assert property (
		clkEnable && regRead && regAddr == 2'h3 |=> regReadData == 24'h000000)
		else $error("unmapped read not zero");
	AST_CTRL_READBACK: assert property (
		sCtrlRead |=> regReadData[23:16] == 8'h00 &&
		regReadData[13:0] == $past(ctrlShadow[13:0]))
		else $error("control readback wrong");
	AST_IRQ_OFF: assert property (!ctrlShadow[11] [*3] |-> !irqRequest)
		else $error("request while disabled");
	AST_MASK_DELAY: assert property (sIrqOffWrite |=> ##2 !irqRequest)
		else $error("request not masked in time");
	AST_VECTOR_SET: assert property (
		irqRequest |-> irqVector inside {8'h16, 8'h18, 8'h1A, 8'h46, 8'h48, 8'h4A} &&
		irqVector[6] == ctrlShadow[12])
		else $error("vector outside bank");
	AST_FLAG_IRQ: assert property (
		sCtrlRead ##1 (regReadData[15:14] != 2'b00 && ctrlShadow[11]) |-> ##1 irqRequest)
		else $error("full flag without request");
	AST_STOP_CLEAR: assert property (sStopRead |=> regReadData[15:14] == 2'b00)
		else $error("flags set in stop");
	AST_STOP_IRQ: assert property (stopMode [*3] |-> !irqRequest)
		else $error("request in stop");
	AST_OFF_IRQ: assert property ((ctrlShadow[1:0] == 2'b00) [*4] |-> !irqRequest)
		else $error("request with receivers off");
endmodule

bind serial_audio_receiver_ctrl serial_audio_receiver_ctrl_sva u_sva (
	.clk(clk), .reset(reset), .clkEnable(clkEnable), .softReset(softReset),
	.stopMode(stopMode), .regAddr(regAddr), .regWriteData(regWriteData),
	.regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
	.irqRequest(irqRequest), .irqVector(irqVector)
);

// *** verilog/rx_shift_channel.sv ***
`include "sai_rx_defs.svh"

module rx_shift_channel (
	// Clock and freeze
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEnable,
	input wire logic clear,
	// Bit stream
	input wire logic shiftEn,
	input wire logic bitIn,
	input wire logic early,
	input wire logic load,
	// Format
	input wire logic [1:0] wordLength,
	input wire logic truncate,
	// Data register
	output logic [`DATA_WIDTH-1:0] dataOut
);

	logic [`SHIFT_WIDTH-1:0] shifter;
	logic [`SHIFT_WIDTH-1:0] word;

	// Serial data enters MSB first
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			shifter <= '0;
		end else if (clkEnable) begin
			if (clear)
				shifter <= '0;
			else if (shiftEn)
				shifter <= {shifter[`SHIFT_WIDTH-2:0], bitIn};
		end
	end

	// Early word select: the bit taken with the change closes the old word
	assign word = early ? {shifter[`SHIFT_WIDTH-2:0], bitIn} : shifter;

	// Data register loads once per complete word
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dataOut <= '0;
		end else if (clkEnable) begin
			if (clear)
				dataOut <= '0;
			else if (load) begin
				case (wordLength)
				`WLEN_16: dataOut <= {word[15:0], 8'h00};
				`WLEN_32: dataOut <= truncate ? word[23:0] : word[31:8];
				default: dataOut <= word[23:0];
				endcase
			end
		end
	end

endmodule

// *** verilog/serial_audio_receiver_ctrl.sv ***
`include "sai_rx_defs.svh"

module serial_audio_receiver_ctrl
	import sai_rx_pkg::*;
(
	// Clock, resets and freeze
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEnable,
	input wire logic softReset,
	input wire logic stopMode,
	// Register port
	input wire logic [1:0] regAddr,
	input wire logic [23:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [23:0] regReadData,
	// Audio link pins
	input wire logic serialClockPin,
	input wire logic rx_word_select_pin,
	input wire logic [1:0] rx_serial_data_in,
	// Interrupt request to the core
	output logic irqRequest,
	output logic [7:0] irqVector
);

	// Vector for the current flag pair, bank chosen by the select bit
	function automatic logic [7:0] selVector(input logic bank, input logic left,
			input logic right);
		logic [7:0] v;
		v = '0;
		case ({left, right})
		2'b10: v = bank ? `VEC_LEFT_HIGH : `VEC_LEFT_LOW;
		2'b01: v = bank ? `VEC_RIGHT_HIGH : `VEC_RIGHT_LOW;
		2'b11: v = bank ? `VEC_EXC_HIGH : `VEC_EXC_LOW;
		default: v = '0;
		endcase
		return v;
	endfunction

	// Register port address decode
	function automatic logic hit(input logic [1:0] addr, input logic [1:0] idx);
		return addr == idx;
	endfunction

	ctrl_type ctrl;
	ctrl_type statusWord;
	pins_type pinMeta;
	pins_type pinSync;
	pins_type pinLast;
	rx_state_type state;

	logic [1:0] enables;
	logic offDelayed;
	logic sectionOff;
	logic sampleEdge;
	logic wsPrev;
	logic wsChange;
	logic wordIsLeft;
	logic leftSeen;
	logic transfer;
	logic leftFull;
	logic rightFull;
	logic [1:0] readMask;
	logic [1:0] dataReadHit;
	logic [1:0] maskAfter;
	logic readsDone;
	logic singleClear;
	logic overrunClear;
	logic statusSeen;
	logic irqEnHold;
	logic irqEnEffective;
	logic [`DATA_WIDTH-1:0] rxData [`NUM_RECEIVERS];

	// Control register, written by software; status bits are not stored here
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl <= '0;
		end else if (clkEnable) begin
			if (softReset)
				ctrl <= '0;
			else if (regWrite && hit(regAddr, `IDX_CTRL))
				ctrl <= ctrl_type'(regWriteData[`CTRL_WIDTH-1:0] & `CTRL_WRITE_MASK);
		end
	end

	assign enables = {ctrl.receiver_b_enable, ctrl.receiver_a_enable};

	// Section drops into its own reset one cycle after both enables go low
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			offDelayed <= 1'b1;
		end else if (clkEnable) begin
			if (softReset)
				offDelayed <= 1'b1;
			else
				offDelayed <= (enables == 2'b00);
		end
	end

	assign sectionOff = stopMode | offDelayed;

	// Two-stage synchroniser on every link pin, then one stage for edges
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pinMeta <= '0;
			pinSync <= '0;
			pinLast <= '0;
		end else if (clkEnable) begin
			pinMeta <= {serialClockPin, rx_word_select_pin, rx_serial_data_in};
			pinSync <= pinMeta;
			pinLast <= pinSync;
		end
	end

	// Sampling edge: rising for negative polarity, falling for positive.
	// The source changes lines on the other edge, so all pins are stable here.
	assign sampleEdge = ctrl.rx_clock_polarity_sel ?
		(pinLast.sck & ~pinSync.sck) :
		(~pinLast.sck & pinSync.sck);

	// Word select as seen at the previous sampling edge
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wsPrev <= 1'b0;
		end else if (clkEnable) begin
			if (softReset)
				wsPrev <= 1'b0;
			else if (sampleEdge)
				wsPrev <= pinSync.ws;
		end
	end

	// A word boundary is any change of word select between sampling edges
	assign wsChange = sampleEdge & (pinSync.ws != wsPrev);

	// The finished word belongs to the channel the old select level marked
	assign wordIsLeft = (wsPrev == ctrl.rx_left_right_polarity);

	// Sequencer: after enabling, the first boundary only aligns, since
	// the word in flight was caught partway and must not be delivered.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= RX_IDLE;
		end else if (clkEnable) begin
			if (softReset) begin
				state <= RX_IDLE;
			end else begin
				case (state)
				RX_IDLE: begin
					if (!sectionOff)
						state <= RX_ALIGN;
				end
				RX_ALIGN: begin
					if (sectionOff)
						state <= RX_IDLE;
					else if (wsChange)
						state <= RX_RUN;
				end
				RX_RUN: begin
					if (sectionOff)
						state <= RX_IDLE;
				end
				default: state <= RX_IDLE;
				endcase
			end
		end
	end

	// Right words are dropped until the first left word has landed
	assign transfer = (state == RX_RUN) & wsChange & ~sectionOff &
		(wordIsLeft | leftSeen);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			leftSeen <= 1'b0;
		end else if (clkEnable) begin
			if (softReset || state != RX_RUN)
				leftSeen <= 1'b0;
			else if (transfer && wordIsLeft)
				leftSeen <= 1'b1;
		end
	end

	// One shift channel per receiver, all stepped by the shared controller
	generate
		for (genvar g = 0; g < `NUM_RECEIVERS; g++) begin : chan
			rx_shift_channel u_shift (
				.clk(clk),
				.reset(reset),
				.clkEnable(clkEnable),
				.clear(softReset | sectionOff),
				.shiftEn(sampleEdge & enables[g]),
				.bitIn(pinSync.sd[g]),
				.early(ctrl.rx_ws_early_sel),
				.load(transfer & enables[g]),
				.wordLength(ctrl.rx_word_length_field),
				.truncate(ctrl.rx_truncate_sel),
				.dataOut(rxData[g])
			);
		end
	endgenerate

	// Data reads that count toward clearing: only enabled receivers matter
	assign dataReadHit[0] = regRead & hit(regAddr, `IDX_DATA_A) & enables[0];
	assign dataReadHit[1] = regRead & hit(regAddr, `IDX_DATA_B) & enables[1];
	assign maskAfter = readMask & ~dataReadHit;
	assign readsDone = (readMask != 2'b00) & (maskAfter == 2'b00);

	// Flags clear only once every enabled data register has been read
	assign singleClear = readsDone & (leftFull ^ rightFull);
	assign overrunClear = readsDone & leftFull & rightFull & statusSeen;

	// Outstanding data reads, reloaded with the enables on each transfer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			readMask <= 2'b00;
		end else if (clkEnable) begin
			if (softReset || sectionOff)
				readMask <= 2'b00;
			else if (transfer)
				readMask <= enables;
			// Status read in overrun restarts the count: all enabled data reads follow it
			else if (regRead && hit(regAddr, `IDX_CTRL) && leftFull && rightFull)
				readMask <= enables;
			else
				readMask <= maskAfter;
		end
	end

	// Status read during overrun is remembered until the data reads follow
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			statusSeen <= 1'b0;
		end else if (clkEnable) begin
			if (softReset || sectionOff || overrunClear || !(leftFull && rightFull))
				statusSeen <= 1'b0;
			else if (regRead && hit(regAddr, `IDX_CTRL))
				statusSeen <= 1'b1;
		end
	end

	// Left full flag; a new transfer beats a clear in the same cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			leftFull <= 1'b0;
		end else if (clkEnable) begin
			if (softReset)
				leftFull <= 1'b0;
			else if (sectionOff)
				leftFull <= 1'b0;
			else if (transfer && wordIsLeft)
				leftFull <= 1'b1;
			else if (singleClear || overrunClear)
				leftFull <= 1'b0;
		end
	end

	// Right full flag, same priorities as the left one
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rightFull <= 1'b0;
		end else if (clkEnable) begin
			if (softReset)
				rightFull <= 1'b0;
			else if (sectionOff)
				rightFull <= 1'b0;
			else if (transfer && !wordIsLeft)
				rightFull <= 1'b1;
			else if (singleClear || overrunClear)
				rightFull <= 1'b0;
		end
	end

	// Enable is held one extra cycle so a clear masks the request late
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irqEnHold <= 1'b0;
		end else if (clkEnable) begin
			if (softReset)
				irqEnHold <= 1'b0;
			else
				irqEnHold <= ctrl.rx_irq_enable;
		end
	end

	assign irqEnEffective = ctrl.rx_irq_enable | irqEnHold;

	// Request and vector registered; flags keep updating when masked
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irqRequest <= 1'b0;
			irqVector <= '0;
		end else if (clkEnable) begin
			if (softReset) begin
				irqRequest <= 1'b0;
				irqVector <= '0;
			end else begin
				irqRequest <= irqEnEffective & (leftFull | rightFull);
				irqVector <= irqEnEffective ?
					selVector(ctrl.rx_vector_bank_sel, leftFull, rightFull) : '0;
			end
		end
	end

	// Readable control/status word: stored controls plus live flags
	always_comb begin
		statusWord = ctrl;
		statusWord.rx_left_full_flag = leftFull;
		statusWord.rx_right_full_flag = rightFull;
	end

	// Read data stands only in the cycle after the read strobe
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			regReadData <= '0;
		end else if (clkEnable) begin
			if (regRead) begin
				case (regAddr)
				`IDX_CTRL: regReadData <= 24'(statusWord);
				`IDX_DATA_A: regReadData <= rxData[0];
				`IDX_DATA_B: regReadData <= rxData[1];
				default: regReadData <= '0;
				endcase
			end else begin
				regReadData <= '0;
			end
		end
	end

endmodule
